/* rtl/reset_cause_flags_and_register_init.sv */
// Reset cause flags and core register initialisation for the processor core
// Functional notes
// - Registers without reset value start unknown and survive all non power-on resets.
// - Watchdog wake-up from low power leaves nearly all registers as they were.
// - Power-on: pc zero, instruction, expiry, sleep flags set, enable set in software mode only; power-up, brownout, stack flags cleared.
// - Pin reset in low-power run: pc zero, set expiry flag, others kept.
// - Pin reset in idle or sleep: pc zero, set expiry flag, clear sleep flag.
// - Watchdog expiry while running: pc zero, clear expiry flag, others kept.
// - Pin reset in full-power run: pc zero, all flags kept.
// - Full stack with fault reset enabled: reset, pc zero, set stack-full flag.
// - Underflow sets its flag and loads pc zero; resets only when enabled.
// - Watchdog in idle or sleep wakes: pc plus two, clear expiry and sleep flags.
// - Interrupt wake clears sleep flag, pc plus two, or vector when interrupts enabled.
// - Software brown-out enable is one after power-on in software mode, kept if set, else zero.
// - Interrupt wake with enables set pushes current pc to stack head.
// - Interrupt wake with enables set advances the return stack pointer.
// - Interrupt wake leaves a request flag set naming its source.
// - Unimplemented register bits always read zero.
// - Pc, latches, table pointer, table latch, stack head clear on every reset; pc also clears on underflow without reset.
// - Stack pointer clears on power/brown-out; fault flags kept otherwise; interrupt controls reset.
// - Brownout flag clears on every brown-out or power-on reset when enabled.
// - Software brown-out enable works only in software mode, otherwise reads zero.
`default_nettype none
`include "rst_cfg.svh"
module reset_cause_flags_and_register_init
	import rst_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic external_reset_pin_n,
	input wire logic brownout_detect,
	input wire logic [1:0] brownout_config_bits,
	input wire logic stack_fault_reset_enable,
	input wire power_mode_t power_mode,
	input wire logic watchdog_expiry,
	input wire logic reset_instruction,
	input wire logic stack_full_event,
	input wire logic stack_underflow_event,
	input wire logic int_wake,
	input wire logic int_wake_high,
	input wire logic [2:0] int_wake_src,
	input wire logic core_pc_load,
	input wire logic [`PC_W-1:0] core_pc_value,
	input wire core_write_t core_wr,
	output core_regs_t core_regs,
	output logic [7:0] reset_cause_register,
	output logic core_reset_pulse,
	output logic core_hold
);
	rst_state_t state_reg;
	rst_state_t state_next;
	logic [`EV_COUNT-1:0] ev_req;
	logic [`EV_COUNT-1:0] ev_grant;
	logic bo_enabled;
	logic in_idle_sleep;
	logic gie_any;
	logic genuine_reset;
	logic sw_bo_keep;

	// ------------------------------------------------------------
	// Event qualification
	// ------------------------------------------------------------
	assign in_idle_sleep = (power_mode == MODE_LP_IDLE) || (power_mode == MODE_SLEEP);
	assign gie_any = state_reg.regs.interrupt_control_1[7] | state_reg.regs.interrupt_control_1[6];
	assign bo_enabled = (brownout_config_bits == `BO_CFG_HW)
		|| ((brownout_config_bits == `BO_CFG_HW_NOSLEEP) && (power_mode != MODE_SLEEP))
		|| ((brownout_config_bits == `BO_CFG_SW) && state_reg.regs.flags.sw_brownout_enable);
	assign sw_bo_keep = (brownout_config_bits == `BO_CFG_SW) && state_reg.regs.flags.sw_brownout_enable;

	always_comb begin
		ev_req = '0;
		ev_req[`EV_BROWNOUT] = state_reg.bod_sync2 & ~state_reg.bod_prev & bo_enabled;
		ev_req[`EV_PIN] = state_reg.pin_prev & ~state_reg.pin_sync2;
		ev_req[`EV_WATCHDOG] = watchdog_expiry;
		ev_req[`EV_STACK_FULL] = stack_full_event;
		ev_req[`EV_STACK_UNDER] = stack_underflow_event;
		ev_req[`EV_INSTR] = reset_instruction;
		ev_req[`EV_INT_WAKE] = int_wake & (power_mode != MODE_FULL_RUN);
	end

	cause_prio #(
		.N(`EV_COUNT)
	) u_prio (
		.req(ev_req),
		.grant(ev_grant)
	);

	// Events that reinitialise the core set rather than resume it
	assign genuine_reset = ev_grant[`EV_BROWNOUT] | ev_grant[`EV_PIN]
		| (ev_grant[`EV_WATCHDOG] & ~in_idle_sleep)
		| (ev_grant[`EV_STACK_FULL] & stack_fault_reset_enable)
		| (ev_grant[`EV_STACK_UNDER] & stack_fault_reset_enable)
		| ev_grant[`EV_INSTR];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.pin_sync1 = external_reset_pin_n;
		state_next.pin_sync2 = state_reg.pin_sync1;
		state_next.pin_prev = state_reg.pin_sync2;
		state_next.bod_sync1 = brownout_detect;
		state_next.bod_sync2 = state_reg.bod_sync1;
		state_next.bod_prev = state_reg.bod_sync2;
		state_next.reset_pulse = genuine_reset;

		// Normal core traffic; events below override it in the same cycle
		if (core_pc_load) begin
			state_next.regs.pc = core_pc_value;
		end
		if (core_wr.en) begin
			case (core_wr.sel)
				SEL_STACK_PTR: begin
					state_next.regs.return_stack_pointer = core_wr.data & `SP_MASK;
				end
				SEL_LATCH_HIGH: begin
					state_next.regs.program_counter_latch_high = core_wr.data;
				end
				SEL_LATCH_UPPER: begin
					state_next.regs.program_counter_latch_upper = core_wr.data[`LATCH_UPPER_W-1:0];
				end
				SEL_TBLPTR_U: begin
					state_next.regs.table_pointer[21:16] = core_wr.data[5:0];
				end
				SEL_TBLPTR_H: begin
					state_next.regs.table_pointer[15:8] = core_wr.data;
				end
				SEL_TBLPTR_L: begin
					state_next.regs.table_pointer[7:0] = core_wr.data;
				end
				SEL_TABLE_LATCH: begin
					state_next.regs.table_latch = core_wr.data;
				end
				SEL_INT_CTRL1: begin
					state_next.regs.interrupt_control_1 = core_wr.data;
				end
				SEL_INT_CTRL2: begin
					state_next.regs.interrupt_control_2 = core_wr.data & `IC2_MASK;
				end
				SEL_INT_CTRL3: begin
					state_next.regs.interrupt_control_3 = core_wr.data & `IC3_MASK;
				end
				SEL_PIR: begin
					state_next.regs.peripheral_request_flags = core_wr.data;
				end
				SEL_CAUSE: begin
					state_next.regs.flags.sw_brownout_enable = core_wr.data[`RC_SW_BO_EN];
					state_next.regs.flags.instruction_reset_flag = core_wr.data[`RC_INSTR];
					state_next.regs.flags.power_up_flag = core_wr.data[`RC_POWER_UP];
					state_next.regs.flags.brownout_flag = core_wr.data[`RC_BROWNOUT];
				end
				SEL_SCRATCH: begin
					state_next.regs.scratch = core_wr.data;
				end
				default: begin
				end
			endcase
		end

		// Core set reinitialisation; scratch is never touched here
		if (genuine_reset) begin
			state_next.regs.pc = `PC_RESET;
			state_next.regs.stack_head = '0;
			state_next.regs.program_counter_latch_high = '0;
			state_next.regs.program_counter_latch_upper = '0;
			state_next.regs.table_pointer = '0;
			state_next.regs.table_latch = '0;
			state_next.regs.return_stack_pointer.ptr = '0;
			state_next.regs.return_stack_pointer.unused = 1'b0;
			state_next.regs.interrupt_control_1 = state_reg.regs.interrupt_control_1 & `IC1_KEEP;
			state_next.regs.interrupt_control_2 = `IC2_RESET;
			state_next.regs.interrupt_control_3 = `IC3_RESET;
			if (!sw_bo_keep) begin
				state_next.regs.flags.sw_brownout_enable = 1'b0;
			end
		end

		// Cause flags per event
		if (ev_grant[`EV_BROWNOUT]) begin
			state_next.regs.flags.instruction_reset_flag = 1'b1;
			state_next.regs.flags.watchdog_expiry_flag = 1'b1;
			state_next.regs.flags.sleep_entry_flag = 1'b1;
			state_next.regs.flags.brownout_flag = 1'b0;
			state_next.regs.return_stack_pointer = '0;
		end
		if (ev_grant[`EV_PIN]) begin
			case (power_mode)
				MODE_LP_RUN: begin
					state_next.regs.flags.watchdog_expiry_flag = 1'b1;
				end
				MODE_LP_IDLE, MODE_SLEEP: begin
					state_next.regs.flags.watchdog_expiry_flag = 1'b1;
					state_next.regs.flags.sleep_entry_flag = 1'b0;
				end
				default: begin
					state_next.regs.flags.watchdog_expiry_flag = state_reg.regs.flags.watchdog_expiry_flag;
				end
			endcase
		end
		if (ev_grant[`EV_WATCHDOG]) begin
			state_next.regs.flags.watchdog_expiry_flag = 1'b0;
			if (in_idle_sleep) begin
				state_next.regs.pc = state_reg.regs.pc + `PC_STEP;
				state_next.regs.flags.sleep_entry_flag = 1'b0;
			end
		end
		if (ev_grant[`EV_STACK_FULL]) begin
			state_next.regs.return_stack_pointer.stack_full_flag = 1'b1;
		end
		if (ev_grant[`EV_STACK_UNDER]) begin
			state_next.regs.return_stack_pointer.stack_underflow_flag = 1'b1;
			state_next.regs.pc = `PC_RESET;
		end
		if (ev_grant[`EV_INSTR]) begin
			state_next.regs.flags.instruction_reset_flag = 1'b0;
		end
		if (ev_grant[`EV_INT_WAKE]) begin
			state_next.regs.flags.sleep_entry_flag = 1'b0;
			state_next.regs.peripheral_request_flags[int_wake_src] = 1'b1;
			if (gie_any) begin
				state_next.regs.stack_head = state_reg.regs.pc;
				state_next.regs.return_stack_pointer.ptr = state_reg.regs.return_stack_pointer.ptr + `SP_STEP;
				state_next.regs.pc = int_wake_high ? `VEC_HIGH : `VEC_LOW;
			end else begin
				state_next.regs.pc = state_reg.regs.pc + `PC_STEP;
			end
		end

		if (brownout_config_bits != `BO_CFG_SW) begin
			state_next.regs.flags.sw_brownout_enable = 1'b0;
		end

		// Power-on: the synchronous reset is the power-on detector
		if (!resetn) begin
			state_next.regs.pc = `PC_RESET;
			state_next.regs.stack_head = '0;
			state_next.regs.program_counter_latch_high = '0;
			state_next.regs.program_counter_latch_upper = '0;
			state_next.regs.table_pointer = '0;
			state_next.regs.table_latch = '0;
			state_next.regs.return_stack_pointer = '0;
			state_next.regs.interrupt_control_1 = state_reg.regs.interrupt_control_1 & `IC1_KEEP;
			state_next.regs.interrupt_control_2 = `IC2_RESET;
			state_next.regs.interrupt_control_3 = `IC3_RESET;
			state_next.regs.flags.sw_brownout_enable = (brownout_config_bits == `BO_CFG_SW);
			state_next.regs.flags.instruction_reset_flag = 1'b1;
			state_next.regs.flags.watchdog_expiry_flag = 1'b1;
			state_next.regs.flags.sleep_entry_flag = 1'b1;
			state_next.regs.flags.power_up_flag = 1'b0;
			state_next.regs.flags.brownout_flag = 1'b0;
			state_next.pin_sync1 = 1'b1;
			state_next.pin_sync2 = 1'b1;
			state_next.pin_prev = 1'b1;
			state_next.bod_sync1 = 1'b0;
			state_next.bod_sync2 = 1'b0;
			state_next.bod_prev = 1'b0;
			state_next.reset_pulse = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign core_regs = state_reg.regs;
	assign reset_cause_register = {1'b0, state_reg.regs.flags.sw_brownout_enable, 1'b0,
		state_reg.regs.flags.instruction_reset_flag, state_reg.regs.flags.watchdog_expiry_flag,
		state_reg.regs.flags.sleep_entry_flag, state_reg.regs.flags.power_up_flag,
		state_reg.regs.flags.brownout_flag};
	assign core_reset_pulse = state_reg.reset_pulse;
	assign core_hold = ~resetn | ~state_reg.pin_sync2 | (state_reg.bod_sync2 & bo_enabled);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_por_flags;
		$rose(resetn) |-> (state_reg.regs.flags[4:0] == 5'h1c) && (state_reg.regs.pc == `PC_RESET)
			&& (state_reg.regs.return_stack_pointer == '0);
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on values wrong");

	property p_pin_lp_run;
		ev_grant[`EV_PIN] && power_mode == MODE_LP_RUN && !core_wr.en
			|=> state_reg.regs.flags.watchdog_expiry_flag && state_reg.regs.pc == `PC_RESET
			&& $stable(state_reg.regs.flags.sleep_entry_flag);
	endproperty
	a_pin_lp_run: assert property (p_pin_lp_run) else $error("pin reset in low-power run wrong");

	property p_pin_idle;
		ev_grant[`EV_PIN] && in_idle_sleep |=> state_reg.regs.flags.watchdog_expiry_flag
			&& !state_reg.regs.flags.sleep_entry_flag && core_reset_pulse;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin reset in idle or sleep wrong");

	property p_wdt_run;
		ev_grant[`EV_WATCHDOG] && !in_idle_sleep |=> !state_reg.regs.flags.watchdog_expiry_flag
			&& state_reg.regs.pc == `PC_RESET && core_reset_pulse;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset while running wrong");

	property p_pin_full;
		ev_grant[`EV_PIN] && power_mode == MODE_FULL_RUN && !core_wr.en
			|=> $stable(state_reg.regs.flags) && state_reg.regs.return_stack_pointer.ptr == '0
			&& $stable(state_reg.regs.return_stack_pointer.stack_full_flag);
	endproperty
	a_pin_full: assert property (p_pin_full) else $error("pin reset in full run changed flags");

	property p_stack_full;
		ev_grant[`EV_STACK_FULL] && stack_fault_reset_enable
			|=> state_reg.regs.return_stack_pointer.stack_full_flag && state_reg.regs.pc == `PC_RESET;
	endproperty
	a_stack_full: assert property (p_stack_full) else $error("stack full reset wrong");

	property p_underflow;
		ev_grant[`EV_STACK_UNDER] |=> state_reg.regs.return_stack_pointer.stack_underflow_flag
			&& state_reg.regs.pc == `PC_RESET && (core_reset_pulse == $past(stack_fault_reset_enable));
	endproperty
	a_underflow: assert property (p_underflow) else $error("stack underflow handling wrong");

	property p_wdt_wake;
		ev_grant[`EV_WATCHDOG] && in_idle_sleep |=> state_reg.regs.pc == $past(state_reg.regs.pc) + `PC_STEP
			&& !state_reg.regs.flags.watchdog_expiry_flag && !state_reg.regs.flags.sleep_entry_flag
			&& !core_reset_pulse;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake-up wrong");

	property p_int_vector;
		ev_grant[`EV_INT_WAKE] && gie_any |=> state_reg.regs.stack_head == $past(state_reg.regs.pc)
			&& state_reg.regs.return_stack_pointer.ptr == $past(state_reg.regs.return_stack_pointer.ptr) + `SP_STEP
			&& state_reg.regs.pc == ($past(int_wake_high) ? `VEC_HIGH : `VEC_LOW);
	endproperty
	a_int_vector: assert property (p_int_vector) else $error("interrupt wake push wrong");

	property p_int_flag;
		ev_grant[`EV_INT_WAKE] |=> state_reg.regs.peripheral_request_flags != 8'h00
			&& !state_reg.regs.flags.sleep_entry_flag;
	endproperty
	a_int_flag: assert property (p_int_flag) else $error("interrupt wake left no flag");

	property p_unimpl;
		!state_reg.regs.return_stack_pointer.unused && reset_cause_register[7] == 1'b0
			&& (state_reg.regs.interrupt_control_2 & ~`IC2_MASK) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

	property p_sw_brownout_enable_mode;
		brownout_config_bits != `BO_CFG_SW |=> !reset_cause_register[`RC_SW_BO_EN];
	endproperty
	a_sw_brownout_enable_mode: assert property (p_sw_brownout_enable_mode) else $error("brown-out enable visible outside software mode");

	property p_instr;
		ev_grant[`EV_INSTR] |=> !state_reg.regs.flags.instruction_reset_flag && core_reset_pulse
			&& $stable(state_reg.regs.flags.watchdog_expiry_flag);
	endproperty
	a_instr: assert property (p_instr) else $error("reset instruction handling wrong");
endmodule // reset_cause_flags_and_register_init
`default_nettype wire

/* rtl/rst_cfg.svh */
// Constants for the reset cause flags and core register initialisation block
`ifndef RST_CFG_SVH
`define RST_CFG_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define PC_W 21
`define SP_W 5
`define LATCH_UPPER_W 5
`define TBLPTR_W 22
`define EV_COUNT 7

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002
`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define SP_STEP 5'h01

// ------------------------------------------------------------
// Event indices, lowest index has priority
// ------------------------------------------------------------
`define EV_BROWNOUT 0
`define EV_PIN 1
`define EV_WATCHDOG 2
`define EV_STACK_FULL 3
`define EV_STACK_UNDER 4
`define EV_INSTR 5
`define EV_INT_WAKE 6

// ------------------------------------------------------------
// Reset values and implemented bit masks
// ------------------------------------------------------------
`define BO_CFG_SW 2'b01
`define BO_CFG_HW_NOSLEEP 2'b10
`define BO_CFG_HW 2'b11
`define IC1_KEEP 8'h01
`define IC2_RESET 8'hf5
`define IC2_MASK 8'hf5
`define IC3_RESET 8'hc0
`define IC3_MASK 8'hdb
`define SP_MASK 8'hdf

// ------------------------------------------------------------
// Cause register bit positions
// ------------------------------------------------------------
`define RC_SW_BO_EN 6
`define RC_INSTR 4
`define RC_POWER_UP 1
`define RC_BROWNOUT 0

`endif

/* rtl/rst_pkg.sv */
// Types for the reset cause flags and core register initialisation block
`default_nettype none
package rst_pkg;
	`include "rst_cfg.svh"

	typedef enum logic [1:0] {
		MODE_FULL_RUN = 2'b00,
		MODE_LP_RUN = 2'b01,
		MODE_LP_IDLE = 2'b10,
		MODE_SLEEP = 2'b11
	} power_mode_t;

	typedef enum logic [3:0] {
		SEL_STACK_PTR = 4'h0,
		SEL_LATCH_HIGH = 4'h1,
		SEL_LATCH_UPPER = 4'h2,
		SEL_TBLPTR_U = 4'h3,
		SEL_TBLPTR_H = 4'h4,
		SEL_TBLPTR_L = 4'h5,
		SEL_TABLE_LATCH = 4'h6,
		SEL_INT_CTRL1 = 4'h7,
		SEL_INT_CTRL2 = 4'h8,
		SEL_INT_CTRL3 = 4'h9,
		SEL_PIR = 4'ha,
		SEL_CAUSE = 4'hb,
		SEL_SCRATCH = 4'hc
	} core_reg_sel_t;

	typedef struct packed {
		logic en;
		core_reg_sel_t sel;
		logic [7:0] data;
	} core_write_t;

	typedef struct packed {
		logic sw_brownout_enable;
		logic instruction_reset_flag;
		logic watchdog_expiry_flag;
		logic sleep_entry_flag;
		logic power_up_flag;
		logic brownout_flag;
	} cause_flags_t;

	typedef struct packed {
		logic stack_full_flag;
		logic stack_underflow_flag;
		logic unused;
		logic [`SP_W-1:0] ptr;
	} stack_ptr_t;

	typedef struct packed {
		logic [`PC_W-1:0] pc;
		logic [`PC_W-1:0] stack_head;
		stack_ptr_t return_stack_pointer;
		logic [7:0] program_counter_latch_high;
		logic [`LATCH_UPPER_W-1:0] program_counter_latch_upper;
		logic [`TBLPTR_W-1:0] table_pointer;
		logic [7:0] table_latch;
		logic [7:0] interrupt_control_1;
		logic [7:0] interrupt_control_2;
		logic [7:0] interrupt_control_3;
		logic [7:0] peripheral_request_flags;
		logic [7:0] scratch;
		cause_flags_t flags;
	} core_regs_t;

	typedef struct packed {
		core_regs_t regs;
		logic pin_sync1;
		logic pin_sync2;
		logic pin_prev;
		logic bod_sync1;
		logic bod_sync2;
		logic bod_prev;
		logic reset_pulse;
	} rst_state_t;
endpackage
`default_nettype wire

/* rtl/cause_prio.sv */
// Fixed priority picker for simultaneous reset and wake events
`default_nettype none
module cause_prio #(
	parameter int N = 7
) (
	input wire logic [N-1:0] req,
	output logic [N-1:0] grant
);
	logic found;

	if (N < 1) begin : g_check
		$error("cause_prio needs at least one request");
	end

	// ------------------------------------------------------------
	// Lowest index wins
	// ------------------------------------------------------------
	always_comb begin
		found = 1'b0;
		grant = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i] && !found) begin
				grant[i] = 1'b1;
				found = 1'b1;
			end
		end
	end
endmodule // cause_prio
`default_nettype wire

/* dv/reset_source_model.sv */
// Model of the reset sources: external reset pin, brown-out detector, watchdog
`default_nettype none
module reset_source_model (
	input wire logic clk,
	output logic pin_n,
	output logic bod,
	output logic dog
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Source drivers, changed on the falling edge
	// ------------------------------------------------------------
	initial begin
		pin_n = 1'b1;
		bod = 1'b0;
		dog = 1'b0;
	end
	// Pin has a pull-up, so release means high
	task automatic pin_drive(input logic v);
		@(negedge clk);
		pin_n = v;
	endtask
	task automatic bod_drive(input logic v);
		@(negedge clk);
		bod = v;
	endtask
	// Watchdog expiry is a single cycle pulse in the core clock domain
	task automatic dog_pulse();
		@(negedge clk);
		dog = 1'b1;
		@(negedge clk);
		dog = 1'b0;
	endtask
endmodule // reset_source_model
`default_nettype wire

/* dv/reset_cause_flags_and_register_init_bench.sv */
// Self-checking bench for the reset cause flags and core register init block
`default_nettype none
`include "rst_cfg.svh"
module reset_cause_flags_and_register_init_bench;
	import rst_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Stimulus and design
	// ------------------------------------------------------------
	logic clk, resetn, pin_n, bod, dog, sfre, rst_ins, s_full, s_unf, iw, iw_hi, pc_ld, pulse, hold;
	logic [1:0] cfg;
	logic [2:0] iw_src;
	power_mode_t mode;
	logic [`PC_W-1:0] pc_val;
	core_write_t wr;
	core_regs_t r;
	logic [7:0] rcr;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	reset_source_model i_src (.clk(clk), .pin_n(pin_n), .bod(bod), .dog(dog));
	reset_cause_flags_and_register_init i_dut (.clk(clk), .resetn(resetn), .external_reset_pin_n(pin_n),
		.brownout_detect(bod), .brownout_config_bits(cfg), .stack_fault_reset_enable(sfre),
		.power_mode(mode), .watchdog_expiry(dog), .reset_instruction(rst_ins), .stack_full_event(s_full),
		.stack_underflow_event(s_unf), .int_wake(iw), .int_wake_high(iw_hi), .int_wake_src(iw_src),
		.core_pc_load(pc_ld), .core_pc_value(pc_val), .core_wr(wr), .core_regs(r),
		.reset_cause_register(rcr), .core_reset_pulse(pulse), .core_hold(hold));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One core write and one pc load in the same cycle
	task automatic prep(input core_reg_sel_t s, input logic [7:0] d, input logic [`PC_W-1:0] p);
		@(negedge clk);
		wr = '{en: 1'b1, sel: s, data: d};
		pc_ld = 1'b1;
		pc_val = p;
		@(negedge clk);
		wr.en = 1'b0;
		pc_ld = 1'b0;
	endtask
	// Core events as {reset instruction, stack full, underflow, interrupt wake}
	task automatic ev(input logic [3:0] m);
		@(negedge clk);
		{rst_ins, s_full, s_unf, iw} = m;
		@(negedge clk);
		{rst_ins, s_full, s_unf, iw} = 4'h0;
	endtask
	task automatic wait_rst();
		for (int i = 0; i < 10 && pulse !== 1'b1; i++) @(negedge clk);
		chk("core_reset_pulse", 1, pulse);
		step(1);
	endtask
	task automatic pin_case(input power_mode_t m, input logic [7:0] e);
		mode = m;
		prep(SEL_TABLE_LATCH, 8'ha5, 21'h000077);
		i_src.pin_drive(1'b0);
		wait_rst();
		chk("pin pc", 0, r.pc);
		chk("pin table_latch", 0, r.table_latch);
		chk("pin stack_head", 0, r.stack_head);
		chk("pin cause", e, rcr);
		chk("pin hold", 1, hold);
		i_src.pin_drive(1'b1);
		step(4);
		chk("pin hold release", 0, hold);
		$display("test pin reset mode %0d done", m);
	endtask
	task automatic wake(input logic hi, input logic [2:0] s, input logic [`PC_W-1:0] pc_e, input int sp_e);
		iw_hi = hi;
		iw_src = s;
		ev(4'b0001);
		step(2);
		chk("wake pc", pc_e, r.pc);
		chk("wake ptr", sp_e, r.return_stack_pointer.ptr);
		chk("wake request flag", 1, r.peripheral_request_flags[s]);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			wrap_up();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{resetn, sfre, rst_ins, s_full, s_unf, iw, iw_hi, pc_ld} = 8'h00;
		{iw_src, pc_val} = '0;
		mode = MODE_FULL_RUN;
		cfg = 2'b01;
		wr = '{en: 1'b0, sel: SEL_SCRATCH, data: 8'h00};
		step(8);
		resetn = 1'b1;
		step(1);
		chk("por pc", 0, r.pc);
		chk("por cause", 8'h5c, rcr);
		chk("por stack ptr", 0, r.return_stack_pointer);
		chk("por interrupt_control_2", 8'hf5, r.interrupt_control_2);
		chk("por interrupt_control_3", 8'hc0, r.interrupt_control_3);
		chk("por table ptr", 0, r.table_pointer);
		$display("test power-on done");
		prep(SEL_TABLE_LATCH, 8'h5a, 21'h000123);
		i_src.dog_pulse();
		wait_rst();
		chk("dog pc", 0, r.pc);
		chk("dog cause", 8'h54, rcr);
		chk("dog table_latch", 0, r.table_latch);
		$display("test watchdog run done");
		pin_case(MODE_FULL_RUN, 8'h54);
		pin_case(MODE_LP_RUN, 8'h5c);
		mode = MODE_SLEEP;
		prep(SEL_INT_CTRL1, 8'h80, 21'h000200);
		wake(1'b1, 3'h3, 21'h000008, 1);
		chk("wake head", 21'h000200, r.stack_head);
		chk("wake cause", 8'h58, rcr);
		wake(1'b0, 3'h5, 21'h000018, 2);
		prep(SEL_INT_CTRL1, 8'h00, 21'h000040);
		wake(1'b0, 3'h1, 21'h000042, 2);
		$display("test interrupt wake done");
		prep(SEL_TABLE_LATCH, 8'h5a, 21'h000300);
		i_src.dog_pulse();
		step(2);
		chk("dog wake pc", 21'h000302, r.pc);
		chk("dog wake cause", 8'h50, rcr);
		chk("dog wake table_latch", 8'h5a, r.table_latch);
		$display("test watchdog wake done");
		pin_case(MODE_LP_IDLE, 8'h58);
		mode = MODE_FULL_RUN;
		sfre = 1'b1;
		prep(SEL_INT_CTRL1, 8'hc1, 21'h000100);
		ev(4'b0100);
		wait_rst();
		chk("full pc", 0, r.pc);
		chk("full interrupt_control_1", 8'h01, r.interrupt_control_1);
		chk("full flag", 1, r.return_stack_pointer.stack_full_flag);
		sfre = 1'b0;
		prep(SEL_SCRATCH, 8'h3c, 21'h000123);
		ev(4'b0010);
		step(2);
		chk("underflow pc", 0, r.pc);
		chk("underflow flag", 1, r.return_stack_pointer.stack_underflow_flag);
		ev(4'b1000);
		wait_rst();
		chk("instr cause", 8'h48, rcr);
		chk("instr full flag", 1, r.return_stack_pointer.stack_full_flag);
		chk("instr scratch", 8'h3c, r.scratch);
		$display("test stack and instruction done");
		i_src.bod_drive(1'b1);
		wait_rst();
		i_src.bod_drive(1'b0);
		step(4);
		chk("brownout cause", 8'h5c, rcr);
		chk("brownout stack ptr", 0, r.return_stack_pointer);
		cfg = 2'b00;
		step(2);
		chk("sw_brownout_enable off", 8'h1c, rcr);
		$display("test brownout done");
		wrap_up();
	end
endmodule // reset_cause_flags_and_register_init_bench
`default_nettype wire
